// [core/crs_regs.sv]
// Core register set with sequencer port and Wishbone debug access
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ns
//
// How it works
// RL1: Six core registers, no memory map
// RL2: Eight-bit accumulator takes ALU results
// RL3: Two eight-bit index registers
// RL4: Prefix selects second index register
// RL5: Interrupt context save leaves second index
// RL6: Sixteen-bit counter in low, high bytes
// RL7: Condition flags pushed and popped whole
// RL8: Half carry from bit three on add
// RL9: Half carry drives jump pair
// RL10: Negative flag copies result bit seven
// RL11: Negative flag drives minus/plus jumps
// RL12: Zero flag set on zero result
// RL13: Zero flag drives equal/not-equal jumps
// RL14: Carry flag set on arithmetic overflow
// RL15: Set/reset carry instructions, carry jumps
// RL16: Carry updated by bit test, shifts
// RL17: Priority bits five and three encode level
// RL18: Interrupt entry loads source priority bits
// RL19: Priority changed by listed instructions
// RL20: Interrupt pushes five bytes, call two
// RL21: Stack pointer resets to 01ff
// RL22: Unaffected flags keep their value
// RL23: Flags reset with bits 7,6,5,3 set
module crs_regs
   import crs_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire crs_cmd_t CMD,
   input wire crs_br_t BR_SEL,
   output logic BR_TAKEN,
   output logic [7:0] ACC,
   output logic [7:0] IDX_X_OUT,
   output logic [7:0] IDX_Y_OUT,
   output logic [15:0] PROGRAM_COUNTER,
   output logic [15:0] STACK_POINTER,
   output logic [7:0] CONDITION_FLAGS,
   output logic [1:0] PRIORITY_LEVEL,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic WB_STB_I,
   input wire logic WB_CYC_I,
   output logic WB_ACK_O
);
   ////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] acc;
   logic [7:0] idx_x;
   logic [7:0] idx_y;
   logic [7:0] program_counter_low;
   logic [7:0] program_counter_high;
   logic [7:0] stack_low;
   logic [7:0] condition_flags;
   logic [7:0] flash_program_control;
   logic [1:0] prio_src;
   logic wb_ack;
   logic [31:0] wb_dat;
   logic br_taken;

   ////////////////////////////////////////////////////////////////
   // Result and condition evaluation
   crs_alu_t alu;
   logic cond;

   crs_alu u_alu (
      .op(CMD.op),
      .a(CMD.a),
      .b(CMD.b),
      .data(CMD.data),
      .cin(CMD.carry_in),
      .res(alu)
   );

   crs_cond u_cond (
      .flags(condition_flags),
      .sel(BR_SEL),
      .taken(cond)
   );

   wire logic cmd_go = CMD.valid;
   wire crs_op_t op = CMD.op;
   wire logic is_arith = (op == CRS_OP_ADD) || (op == CRS_OP_ADC) || (op == CRS_OP_SUB) || (op == CRS_OP_SBC);
   wire logic is_addc = (op == CRS_OP_ADD) || (op == CRS_OP_ADC);
   wire logic is_data = is_arith || (op == CRS_OP_LOGIC) || (op == CRS_OP_LOAD) || (op == CRS_OP_SHIFT);
   wire logic is_prio = (op == CRS_OP_RIM) || (op == CRS_OP_SIM) || (op == CRS_OP_HALT) || (op == CRS_OP_WFI);
   // Disable forces level 3, enable forces main level
   wire logic [1:0] prio_new = (op == CRS_OP_SIM) ? PRIO_DISABLED : (op == CRS_OP_RIM) ? PRIO_MAIN : CMD.prio; // RL19

   ////////////////////////////////////////////////////////////////
   // Flag update
   logic [7:0] next_flags;
   always_comb begin
      next_flags = condition_flags; // RL22
      if (cmd_go) begin
         if (is_data) begin
            next_flags[FLAG_N] = alu.result[7]; // RL10
            next_flags[FLAG_Z] = (alu.result == 8'h00); // RL12
         end
         if (is_addc) begin
            next_flags[FLAG_H] = alu.half; // RL8
         end
         if (is_arith || (op == CRS_OP_SHIFT) || (op == CRS_OP_BTJ)) begin
            next_flags[FLAG_C] = alu.carry; // RL14 RL16
         end
         if (op == CRS_OP_SCF) begin
            next_flags[FLAG_C] = 1'b1; // RL15
         end
         if (op == CRS_OP_RCF) begin
            next_flags[FLAG_C] = 1'b0; // RL15
         end
         if (is_prio || (op == CRS_OP_INTENT)) begin
            next_flags[FLAG_IH] = prio_new[1]; // RL17 RL18 RL19
            next_flags[FLAG_IL] = prio_new[0]; // RL17 RL18 RL19
         end
         if ((op == CRS_OP_POPCC) || (op == CRS_OP_INTERRUPT_RETURN_INSTR)) begin
            next_flags = CMD.data; // RL7 RL19
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Stack pointer motion
   logic [7:0] next_stack;
   always_comb begin
      next_stack = stack_low;
      if (cmd_go) begin
         case (op)
            CRS_OP_INTENT: next_stack = stack_low - 8'h05; // RL20
            CRS_OP_INTERRUPT_RETURN_INSTR: next_stack = stack_low + 8'h05; // RL20
            CRS_OP_CALL: next_stack = stack_low - 8'h02; // RL20
            CRS_OP_PUSH: next_stack = stack_low - 8'h01;
            CRS_OP_POP, CRS_OP_POPCC: next_stack = stack_low + 8'h01;
            CRS_OP_RSP: next_stack = SP_RESET[7:0]; // RL21
            default: next_stack = stack_low;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Wishbone decode
   wire logic wb_req = WB_CYC_I && WB_STB_I && !wb_ack;
   wire logic wb_wr = wb_req && WB_WE_I && WB_SEL_I[0];
   wire logic [7:0] wb_byte = WB_DAT_I[7:0];
   wire logic [7:0] wb_idx = WB_ADR_I;
   logic [7:0] rd_byte;
   always_comb begin
      case (wb_idx)
         IDX_ACC: rd_byte = acc;
         IDX_X: rd_byte = idx_x;
         IDX_Y: rd_byte = idx_y;
         IDX_PCL: rd_byte = program_counter_low;
         IDX_PCH: rd_byte = program_counter_high;
         IDX_SPL: rd_byte = stack_low;
         IDX_FLAGS: rd_byte = condition_flags;
         IDX_PRIO_SRC: rd_byte = {6'h00, prio_src};
         IDX_FLASH_CTRL: rd_byte = flash_program_control;
         default: rd_byte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // Data registers
   wire logic wr_idx = cmd_go && (CMD.dst == CRS_DST_IDX) && is_data;
   wire logic wr_acc = cmd_go && (CMD.dst == CRS_DST_ACC) && is_data;
   wire logic wr_x = wr_idx && !CMD.prefix_y; // RL3 RL4
   wire logic wr_y = wr_idx && CMD.prefix_y; // RL4 RL5
   wire logic wr_pcl = cmd_go && (CMD.dst == CRS_DST_PCL);
   wire logic wr_pch = cmd_go && (CMD.dst == CRS_DST_PCH);

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         acc <= 8'h00;
         idx_x <= 8'h00;
         idx_y <= 8'h00;
         program_counter_low <= 8'h00;
         program_counter_high <= 8'h00;
      end else if (wb_wr) begin
         if (wb_idx == IDX_ACC) acc <= wb_byte;
         if (wb_idx == IDX_X) idx_x <= wb_byte;
         if (wb_idx == IDX_Y) idx_y <= wb_byte;
         if (wb_idx == IDX_PCL) program_counter_low <= wb_byte;
         if (wb_idx == IDX_PCH) program_counter_high <= wb_byte;
      end else begin
         if (wr_acc) acc <= alu.result; // RL2
         if (wr_x) idx_x <= alu.result; // RL3
         if (wr_y) idx_y <= alu.result; // RL4
         if (wr_pcl) program_counter_low <= CMD.data; // RL6
         if (wr_pch) program_counter_high <= CMD.data; // RL6
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         condition_flags <= FLAGS_RESET; // RL23
         stack_low <= SP_RESET[7:0]; // RL21
         flash_program_control <= FLASH_CTRL_RESET;
         prio_src <= PRIO_MAIN;
      end else if (wb_wr) begin
         if (wb_idx == IDX_FLAGS) condition_flags <= wb_byte;
         if (wb_idx == IDX_SPL) stack_low <= wb_byte;
         if (wb_idx == IDX_FLASH_CTRL) flash_program_control <= wb_byte;
         if (wb_idx == IDX_PRIO_SRC) prio_src <= wb_byte[1:0];
      end else begin
         condition_flags <= next_flags;
         stack_low <= next_stack;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Bus answer and outputs
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         wb_ack <= 1'b0;
         wb_dat <= 32'h00000000;
         br_taken <= 1'b0;
      end else begin
         wb_ack <= wb_req;
         wb_dat <= wb_req ? {24'h000000, rd_byte} : 32'h00000000;
         br_taken <= cond;
      end
   end

   assign WB_ACK_O = wb_ack;
   assign WB_DAT_O = wb_dat;
   assign BR_TAKEN = br_taken;
   assign ACC = acc; // RL1
   assign IDX_X_OUT = idx_x;
   assign IDX_Y_OUT = idx_y;
   assign PROGRAM_COUNTER = {program_counter_high, program_counter_low}; // RL6
   assign STACK_POINTER = {SP_HIGH_FIXED, stack_low}; // RL21
   assign CONDITION_FLAGS = condition_flags;
   assign PRIORITY_LEVEL = {condition_flags[FLAG_IH], condition_flags[FLAG_IL]}; // RL17
endmodule

// [core/crs_pkg.sv]
// Shared constants and types of the core register set
package crs_pkg;
   localparam int CRS_DW = 8;
   // Condition flag bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_IL = 3;
   localparam int FLAG_H = 4;
   localparam int FLAG_IH = 5;
   localparam logic [7:0] FLAGS_RESET = 8'he8;
   localparam logic [7:0] FLASH_CTRL_RESET = 8'h00;
   localparam logic [15:0] SP_RESET = 16'h01ff;
   localparam logic [7:0] SP_HIGH_FIXED = 8'h01;
   localparam logic [1:0] PRIO_MAIN = 2'h2;
   localparam logic [1:0] PRIO_DISABLED = 2'h3;
   // Wishbone word addresses (byte address = 4 * index)
   localparam logic [7:0] IDX_FLASH_CTRL = 8'h29;
   localparam logic [7:0] IDX_ACC = 8'h00;
   localparam logic [7:0] IDX_X = 8'h01;
   localparam logic [7:0] IDX_Y = 8'h02;
   localparam logic [7:0] IDX_PCL = 8'h03;
   localparam logic [7:0] IDX_PCH = 8'h04;
   localparam logic [7:0] IDX_SPL = 8'h05;
   localparam logic [7:0] IDX_FLAGS = 8'h06;
   localparam logic [7:0] IDX_PRIO_SRC = 8'h07;

   typedef enum logic [4:0] {
      CRS_OP_NONE = 5'h00, CRS_OP_ADD = 5'h01, CRS_OP_ADC = 5'h02, CRS_OP_SUB = 5'h03,
      CRS_OP_SBC = 5'h04, CRS_OP_LOGIC = 5'h05, CRS_OP_LOAD = 5'h06, CRS_OP_SHIFT = 5'h07,
      CRS_OP_BTJ = 5'h08, CRS_OP_SCF = 5'h09, CRS_OP_RCF = 5'h0a, CRS_OP_RIM = 5'h0b,
      CRS_OP_SIM = 5'h0c, CRS_OP_INTERRUPT_RETURN_INSTR = 5'h0d, CRS_OP_HALT = 5'h0e, CRS_OP_WFI = 5'h0f,
      CRS_OP_POPCC = 5'h10, CRS_OP_INTENT = 5'h11, CRS_OP_RSP = 5'h12, CRS_OP_CALL = 5'h13,
      CRS_OP_PUSH = 5'h14, CRS_OP_POP = 5'h15
   } crs_op_t;

   typedef enum logic [2:0] {
      CRS_DST_NONE = 3'h0, CRS_DST_ACC = 3'h1, CRS_DST_IDX = 3'h2, CRS_DST_PCL = 3'h3, CRS_DST_PCH = 3'h4
   } crs_dst_t;

   typedef enum logic [3:0] {
      CRS_BR_H = 4'h0, CRS_BR_NH = 4'h1, CRS_BR_MI = 4'h2, CRS_BR_PL = 4'h3,
      CRS_BR_EQ = 4'h4, CRS_BR_NE = 4'h5, CRS_BR_C = 4'h6, CRS_BR_NC = 4'h7
   } crs_br_t;

   typedef struct packed {
      logic valid;
      crs_op_t op;
      crs_dst_t dst;
      logic prefix_y;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] data;
      logic carry_in;
      logic [1:0] prio;
   } crs_cmd_t;

   typedef struct packed {
      logic [7:0] result;
      logic half;
      logic carry;
   } crs_alu_t;
endpackage

// [core/crs_alu.sv]
// Result and flag source for register set updates
`timescale 1ns/1ns
module crs_alu
   import crs_pkg::*;
(
   input wire crs_op_t op,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic [7:0] data,
   input wire logic cin,
   output crs_alu_t res
);
   wire logic use_c = (op == CRS_OP_ADC) || (op == CRS_OP_SBC);
   wire logic [4:0] lo_add = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, use_c & cin};
   wire logic [8:0] add9 = {1'b0, a} + {1'b0, b} + {8'h00, use_c & cin};
   wire logic [8:0] sub9 = {1'b0, a} - {1'b0, b} - {8'h00, use_c & cin};
   wire logic is_add = (op == CRS_OP_ADD) || (op == CRS_OP_ADC);
   wire logic is_sub = (op == CRS_OP_SUB) || (op == CRS_OP_SBC);

   wire logic [7:0] res_byte = is_add ? add9[7:0] : is_sub ? sub9[7:0] : data;
   wire logic res_carry = is_add ? add9[8] : is_sub ? sub9[8] : cin; // RL14
   assign res = '{result: res_byte, half: lo_add[4], carry: res_carry}; // RL8
endmodule

// [core/crs_cond.sv]
// Branch condition evaluation from condition flags
`timescale 1ns/1ns
module crs_cond
   import crs_pkg::*;
(
   input wire logic [7:0] flags,
   input wire crs_br_t sel,
   output logic taken
);
   always_comb begin
      case (sel)
         CRS_BR_H: taken = flags[FLAG_H]; // RL9
         CRS_BR_NH: taken = !flags[FLAG_H]; // RL9
         CRS_BR_MI: taken = flags[FLAG_N]; // RL11
         CRS_BR_PL: taken = !flags[FLAG_N]; // RL11
         CRS_BR_EQ: taken = flags[FLAG_Z]; // RL13
         CRS_BR_NE: taken = !flags[FLAG_Z]; // RL13
         CRS_BR_C: taken = flags[FLAG_C]; // RL15
         CRS_BR_NC: taken = !flags[FLAG_C]; // RL15
         default: taken = 1'b0;
      endcase
   end
endmodule

// [test/crs_regs_asserts.sv]
// Port checks of the core register set
`timescale 1ns/1ns
module crs_regs_asserts
   import crs_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire crs_cmd_t CMD,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   input wire logic [31:0] WB_DAT_O,
   input wire logic [7:0] ACC,
   input wire logic [7:0] IDX_Y_OUT,
   input wire logic [15:0] STACK_POINTER,
   input wire logic [7:0] CONDITION_FLAGS,
   input wire logic [1:0] PRIORITY_LEVEL
);
   wire bus = WB_CYC_I && WB_STB_I;
   wire go = CMD.valid && !bus;
   wire add = go && CMD.op == CRS_OP_ADD && !CMD.carry_in && !CONDITION_FLAGS[FLAG_C];
   wire half_in = ({1'b0, CMD.a[3:0]} + {1'b0, CMD.b[3:0]}) > 5'h0f;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   ////////////////////////////////////////////////////////////
   AST_ACK_LATE: assert property (bus && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack not one cycle after request");
   AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
      else $error("read data outside ack");
   AST_PRIO_MAP: assert property (PRIORITY_LEVEL == {CONDITION_FLAGS[FLAG_IH], CONDITION_FLAGS[FLAG_IL]})
      else $error("priority level not flag bits");
   AST_SP_HIGH: assert property (STACK_POINTER[15:8] == SP_HIGH_FIXED)
      else $error("stack high byte moved");
   AST_SET_C: assert property (go && CMD.op == CRS_OP_SCF |=> CONDITION_FLAGS[FLAG_C])
      else $error("carry not set");
   AST_CLR_C: assert property (go && CMD.op == CRS_OP_RCF |=> !CONDITION_FLAGS[FLAG_C])
      else $error("carry not cleared");
   AST_ADD_NZ: assert property (add && CMD.dst == CRS_DST_ACC |=>
      CONDITION_FLAGS[FLAG_Z] == (ACC == 8'h00) && CONDITION_FLAGS[FLAG_N] == ACC[7])
      else $error("sign or zero flag wrong");
   AST_HALF: assert property (add |=> CONDITION_FLAGS[FLAG_H] == $past(half_in))
      else $error("half carry wrong");
   AST_Y_KEEP: assert property (go && CMD.op == CRS_OP_INTENT |=> $stable(IDX_Y_OUT))
      else $error("second index touched");
   AST_INT_PRIO: assert property (go && CMD.op == CRS_OP_INTENT |=> PRIORITY_LEVEL == $past(CMD.prio))
      else $error("entry priority wrong");
   AST_HOLD: assert property (!CMD.valid && !bus |=> $stable(CONDITION_FLAGS))
      else $error("flags changed while idle");
endmodule
bind crs_regs crs_regs_asserts chk_i (.MCLK(MCLK), .RST_B(RST_B), .CMD(CMD), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .ACC(ACC), .IDX_Y_OUT(IDX_Y_OUT),
   .STACK_POINTER(STACK_POINTER), .CONDITION_FLAGS(CONDITION_FLAGS), .PRIORITY_LEVEL(PRIORITY_LEVEL));

// [test/crs_seq_model.sv]
// Sequencer stand-in issuing register set commands
`timescale 1ns/1ns
module crs_seq_model
   import crs_pkg::*;
(
   input wire logic MCLK,
   output crs_cmd_t CMD
);
   initial CMD = '0;
   // One-cycle command pulse, operand also used as data
   task automatic issue(input crs_op_t op, input crs_dst_t dst = CRS_DST_NONE, input logic [7:0] a = 8'h00,
      input logic [7:0] b = 8'h00, input logic py = 1'b0, input logic [1:0] pr = 2'h0);
      @(posedge MCLK);
      CMD <= '{1'b1, op, dst, py, a, b, a, 1'b0, pr};
      @(posedge MCLK);
      CMD.valid <= 1'b0;
   endtask
endmodule

// [test/crs_regs_tb.sv]
// Self-checking bench of the core register set
`timescale 1ns/1ns
module crs_regs_tb
   import crs_pkg::*;
;
   logic MCLK = 1'b0;
   logic RST_B = 1'b0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [3:0] sel = 4'h0;
   crs_br_t br = CRS_BR_H;
   crs_cmd_t cmd;
   int fails = 0;
   int tests_run = 0;
   localparam logic [7:0] BEXP = 8'h66;
   always #5 MCLK = ~MCLK;
   crs_seq_model seq (.MCLK(MCLK), .CMD(cmd));
   crs_regs uut (.MCLK(MCLK), .RST_B(RST_B), .CMD(cmd), .BR_SEL(br), .BR_TAKEN(), .ACC(), .IDX_X_OUT(),
      .IDX_Y_OUT(), .PROGRAM_COUNTER(), .STACK_POINTER(), .CONDITION_FLAGS(), .PRIORITY_LEVEL(),
      .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(), .WB_WE_I(we), .WB_SEL_I(sel), .WB_STB_I(stb),
      .WB_CYC_I(cyc), .WB_ACK_O());
   ////////////////////////////////////////////////////////////
   task chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task wb(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
      @(posedge MCLK);
      adr <= a;
      we <= w;
      wdat <= {24'h0, d};
      sel <= s;
      cyc <= 1'b1;
      stb <= 1'b1;
      do begin
         @(posedge MCLK);
      end while (uut.WB_ACK_O !== 1'b1);
      rdat = uut.WB_DAT_O;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      wb(a, 1'b0, 8'h00, 4'hf);
      chk(rdat, e);
   endtask
   task report_and_stop;
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge MCLK);
      RST_B <= 1'b1;
      #1;
      chk(uut.CONDITION_FLAGS, FLAGS_RESET);
      chk(uut.STACK_POINTER, SP_RESET);
      chk(uut.BR_TAKEN, 1'b0);
      $display("test reset done");
      seq.issue(CRS_OP_ADD, CRS_DST_ACC, 8'h0f, 8'h01);
      #1 chk(uut.ACC, 8'h10);
      chk(uut.CONDITION_FLAGS, 8'hf8);
      seq.issue(CRS_OP_ADD, CRS_DST_ACC, 8'h80, 8'h80);
      #1 chk(uut.CONDITION_FLAGS, 8'heb);
      seq.issue(CRS_OP_LOAD, CRS_DST_ACC, 8'h80);
      #1 chk(uut.CONDITION_FLAGS, 8'hed);
      for (int i = 0; i < 8; i++) begin
         @(posedge MCLK);
         br <= crs_br_t'(i);
         @(posedge MCLK);
         #1 chk(uut.BR_TAKEN, BEXP[i]);
      end
      seq.issue(CRS_OP_RCF);
      #1 chk(uut.CONDITION_FLAGS, 8'hec);
      seq.issue(CRS_OP_SCF);
      #1 chk(uut.CONDITION_FLAGS, 8'hed);
      seq.issue(CRS_OP_SHIFT);
      #1 chk(uut.CONDITION_FLAGS[FLAG_C], 1'b0);
      $display("test flags done");
      seq.issue(CRS_OP_LOAD, CRS_DST_IDX, 8'h5a, 8'h00, 1'b1);
      #1 chk(uut.IDX_Y_OUT, 8'h5a);
      chk(uut.IDX_X_OUT, 8'h00);
      seq.issue(CRS_OP_LOAD, CRS_DST_IDX, 8'h3c);
      #1 chk(uut.IDX_X_OUT, 8'h3c);
      seq.issue(CRS_OP_INTENT, CRS_DST_NONE, 8'h00, 8'h00, 1'b0, 2'h1);
      #1 chk(uut.PRIORITY_LEVEL, 2'h1);
      chk(uut.IDX_Y_OUT, 8'h5a);
      chk(uut.STACK_POINTER, 16'h01fa);
      seq.issue(CRS_OP_SIM);
      #1 chk(uut.PRIORITY_LEVEL, PRIO_DISABLED);
      seq.issue(CRS_OP_RIM);
      #1 chk(uut.PRIORITY_LEVEL, PRIO_MAIN);
      seq.issue(CRS_OP_INTERRUPT_RETURN_INSTR, CRS_DST_NONE, 8'he5);
      #1 chk(uut.CONDITION_FLAGS, 8'he5);
      chk(uut.STACK_POINTER, SP_RESET);
      seq.issue(CRS_OP_CALL);
      #1 chk(uut.STACK_POINTER, 16'h01fd);
      seq.issue(CRS_OP_RSP);
      #1 chk(uut.STACK_POINTER, SP_RESET);
      $display("test stack done");
      rd(IDX_FLASH_CTRL, FLASH_CTRL_RESET);
      wb(IDX_FLASH_CTRL, 1'b1, 8'ha5, 4'hf);
      rd(IDX_FLASH_CTRL, 32'ha5);
      wb(IDX_FLASH_CTRL, 1'b1, 8'h11, 4'h0);
      rd(IDX_FLASH_CTRL, 32'ha5);
      wb(8'h30, 1'b1, 8'hff, 4'hf);
      rd(8'h30, 32'h0);
      wb(IDX_PCL, 1'b1, 8'h34, 4'hf);
      wb(IDX_PCH, 1'b1, 8'h12, 4'hf);
      chk(uut.PROGRAM_COUNTER, 16'h1234);
      rd(IDX_ACC, 32'h80);
      rd(IDX_Y, 32'h5a);
      rd(IDX_FLAGS, 32'he5);
      $display("test bus done");
      seq.issue(CRS_OP_POPCC, CRS_DST_NONE, 8'hea);
      #1 chk(uut.CONDITION_FLAGS, 8'hea);
      chk(uut.STACK_POINTER, 16'h0100);
      seq.issue(CRS_OP_PUSH);
      #1 chk(uut.STACK_POINTER, SP_RESET);
      seq.issue(CRS_OP_SUB, CRS_DST_ACC, 8'h10, 8'h20);
      #1 chk(uut.ACC, 8'hf0);
      chk(uut.CONDITION_FLAGS, 8'hed);
      seq.issue(CRS_OP_LOGIC);
      #1 chk(uut.CONDITION_FLAGS, 8'heb);
      seq.issue(CRS_OP_BTJ);
      #1 chk(uut.CONDITION_FLAGS, 8'hea);
      @(posedge MCLK);
      RST_B <= 1'b0;
      repeat (2) @(posedge MCLK);
      RST_B <= 1'b1;
      #1 chk(uut.CONDITION_FLAGS, FLAGS_RESET);
      chk(uut.ACC, 8'h00);
      chk(uut.STACK_POINTER, SP_RESET);
      seq.issue(CRS_OP_ADD, CRS_DST_ACC, 8'h01, 8'h02);
      #1 chk(uut.ACC, 8'h03);
      $display("test ops done");
      report_and_stop;
   end
   initial begin
      #20000;
      fails++;
      report_and_stop;
   end
endmodule
